// ---- core/cpu_trap_exception_entry.sv ----
// trap and software interrupt entry sequencer with apb control registers
// Notes on behaviour
// - vector table occupies bytes zero to 3ffh
// - entry holds two words: pointer and segment
// - flags pushed first on every entry
// - then interrupt-enable and step bits cleared
// - push segment, pointer, then load from table
// - software traps bypass the interrupt controller
// - software beats hardware; nmi beats step and maskable
// - eight execution traps; 32-255 for users
// - divide overflow raises type 0
// - step flag traps type 1 after instruction
// - step resumes one instruction after return
// - one-byte breakpoint raises type 3 always
// - overflow trap instruction raises 4 if set
// - bounds read from memory; outside raises 5
// - undefined opcode raises type 6
// - escape raises 7; enhanced needs enable
// - compatible or narrow bus: always type 7
// - escape return points at instruction or prefix
// - two-byte trap takes type from byte two
// - software entries run no acknowledge cycles
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
module cpu_trap_exception_entry #(
	parameter bit NARROW_BUS = 1'b0
) (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// execution unit
	input wire logic retire_valid,
	input wire trap_pkg::retire_s retire,
	output logic busy,
	output logic entry_valid,
	output trap_pkg::entry_s entry,
	// hardware requests
	input wire logic nmi_pin,
	input wire logic intr_req,
	input wire logic [7:0] intr_type,
	output logic hw_taken,
	// system memory
	output trap_pkg::mem_req_s mem,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata
);
	import trap_pkg::*;

	typedef enum logic [3:0] {
		S_IDLE, S_BND_LO, S_BND_HI, S_PSH_F, S_PSH_CS, S_PSH_OFS, S_VEC_OFS, S_VEC_CS, S_FINISH
	} state_e;

	state_e state;
	logic [1:0] ctrl;
	logic [31:0] count;
	logic [7:0] last_type;
	logic nmi_s1, nmi_s2, nmi_d, nmi_pend, nmi_take;
	logic [15:0] w_flags, w_cs, w_ofs, w_ss, w_sp, w_idx, w_lo, w_bseg, w_bofs, w_start;
	logic [7:0] w_type;
	logic is_escape, escape_trap, sw_hit, sw_at_start, do_bound;
	logic [7:0] sw_type;
	logic [15:0] src_flags;
	logic late_hit, late_hw, late_nmi, out_of_range, acked;
	logic [7:0] late_type;

	function automatic logic [19:0] phys(input logic [15:0] seg, input logic [15:0] ofs);
		phys = {seg, 4'h0} + {4'h0, ofs};
	endfunction

	// decode of the retiring instruction; these never reach the controller
	always_comb begin
		is_escape = (retire.opcode & OP_ESCAPE_MASK) == OP_ESCAPE_BASE;
		// enable bit matters only in enhanced mode on the wide bus
		escape_trap = is_escape && (!ctrl[CTRL_ENHANCED] || NARROW_BUS || ctrl[CTRL_ESCAPE_EN]);
		sw_hit = 1'b1;
		sw_at_start = 1'b0;
		sw_type = TYPE_DIVIDE;
		do_bound = 1'b0;
		if (retire.div_error) begin
			sw_type = TYPE_DIVIDE;
		end else if (retire.undefined) begin
			sw_type = TYPE_UNDEFINED;
			sw_at_start = 1'b1;
		end else if (retire.opcode == OP_BREAK) begin
			sw_type = TYPE_BREAK;
		end else if (retire.opcode == OP_SOFT_TRAP) begin
			sw_type = retire.imm8;
		end else if (retire.opcode == OP_TRAP_OVF && retire.flags[FL_OVF]) begin
			sw_type = TYPE_OVERFLOW;
		end else if (escape_trap) begin
			sw_type = TYPE_ESCAPE;
			sw_at_start = 1'b1;
		end else begin
			sw_hit = 1'b0;
			do_bound = retire.opcode == OP_BOUNDS;
		end
	end

	// requests taken after the instruction: nmi, then step, then maskable
	always_comb begin
		src_flags = (state == S_IDLE) ? retire.flags : w_flags;
		late_hit = 1'b1;
		late_hw = 1'b0;
		late_nmi = 1'b0;
		late_type = TYPE_NMI;
		if (nmi_pend) begin
			late_nmi = 1'b1;
		end else if (src_flags[FL_STEP]) begin
			// flags are those at instruction start, so a return that restores
			// the step bit lets exactly one instruction run first
			late_type = TYPE_STEP;
		end else if (intr_req && src_flags[FL_INTR]) begin
			late_type = intr_type;
			late_hw = 1'b1;
		end else begin
			late_hit = 1'b0;
		end
	end

	// bounds compare and handshake helpers
	always_comb begin
		acked = mem.req && mem_ack;
		out_of_range = ($signed(w_idx) < $signed(w_lo)) || ($signed(w_idx) > $signed(mem_rdata));
		nmi_take = (state == S_FINISH && nmi_pend)
			|| (state == S_IDLE && retire_valid && !sw_hit && !do_bound && late_nmi)
			|| (state == S_BND_HI && acked && !out_of_range && late_nmi);
	end

	// nmi pin: two-stage synchroniser, then rising edge is latched
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			nmi_s1 <= 1'b0;
			nmi_s2 <= 1'b0;
			nmi_d <= 1'b0;
		end else begin
			nmi_s1 <= nmi_pin;
			nmi_s2 <= nmi_s1;
			nmi_d <= nmi_s2;
		end
	end

	// a new edge in the taking cycle stays pending, so none is lost
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			nmi_pend <= 1'b0;
		end else begin
			nmi_pend <= (nmi_s2 && !nmi_d) || (nmi_pend && !nmi_take);
		end
	end

	// entry sequencer; each memory access spends one issue cycle
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= S_IDLE;
			busy <= 1'b0;
			hw_taken <= 1'b0;
			mem <= '0;
			{w_flags, w_cs, w_ofs, w_ss, w_sp, w_idx, w_lo, w_bseg, w_bofs, w_start} <= '0;
			w_type <= 8'h00;
		end else begin
			hw_taken <= 1'b0;
			unique case (state)
			S_IDLE: begin
				if (retire_valid) begin
					w_flags <= retire.flags;
					w_cs <= retire.cs;
					w_ss <= retire.ss;
					w_sp <= retire.sp;
					w_idx <= retire.index;
					w_bseg <= retire.bound_seg;
					w_bofs <= retire.bound_ofs;
					w_start <= retire.start_ofs;
					w_ofs <= sw_at_start ? retire.start_ofs : retire.next_ofs;
					if (sw_hit) begin
						w_type <= sw_type;
						state <= S_PSH_F;
						busy <= 1'b1;
					end else if (do_bound) begin
						state <= S_BND_LO;
						busy <= 1'b1;
					end else if (late_hit) begin
						w_type <= late_type;
						hw_taken <= late_hw;
						state <= S_PSH_F;
						busy <= 1'b1;
					end
				end
			end
			S_BND_LO: begin
				if (acked) begin
					mem.req <= 1'b0;
					w_lo <= mem_rdata;
					state <= S_BND_HI;
				end else if (!mem.req) begin
					mem <= '{req: 1'b1, we: 1'b0, addr: phys(w_bseg, w_bofs), wdata: 16'h0000};
				end
			end
			S_BND_HI: begin
				if (acked) begin
					mem.req <= 1'b0;
					if (out_of_range) begin
						// restartable: return to the bounds instruction itself
						// the retire bus is only valid with its strobe, so use the copy
						w_type <= TYPE_BOUNDS;
						w_ofs <= w_start;
						state <= S_PSH_F;
					end else if (late_hit) begin
						w_type <= late_type;
						hw_taken <= late_hw;
						state <= S_PSH_F;
					end else begin
						state <= S_IDLE;
						busy <= 1'b0;
					end
				end else if (!mem.req) begin
					mem <= '{req: 1'b1, we: 1'b0, addr: phys(w_bseg, w_bofs + 16'h0002),
						wdata: 16'h0000};
				end
			end
			S_PSH_F: begin
				if (acked) begin
					mem.req <= 1'b0;
					w_sp <= w_sp - 16'h0002;
					w_flags[FL_INTR] <= 1'b0;
					w_flags[FL_STEP] <= 1'b0;
					state <= S_PSH_CS;
				end else if (!mem.req) begin
					mem <= '{req: 1'b1, we: 1'b1, addr: phys(w_ss, w_sp - 16'h0002),
						wdata: w_flags};
				end
			end
			S_PSH_CS: begin
				if (acked) begin
					mem.req <= 1'b0;
					w_sp <= w_sp - 16'h0002;
					state <= S_PSH_OFS;
				end else if (!mem.req) begin
					mem <= '{req: 1'b1, we: 1'b1, addr: phys(w_ss, w_sp - 16'h0002),
						wdata: w_cs};
				end
			end
			S_PSH_OFS: begin
				if (acked) begin
					mem.req <= 1'b0;
					w_sp <= w_sp - 16'h0002;
					state <= S_VEC_OFS;
				end else if (!mem.req) begin
					mem <= '{req: 1'b1, we: 1'b1, addr: phys(w_ss, w_sp - 16'h0002),
						wdata: w_ofs};
				end
			end
			S_VEC_OFS: begin
				if (acked) begin
					mem.req <= 1'b0;
					w_ofs <= mem_rdata;
					state <= S_VEC_CS;
				end else if (!mem.req) begin
					mem <= '{req: 1'b1, we: 1'b0, addr: VEC_BASE + {10'h000, w_type, 2'b00},
						wdata: 16'h0000};
				end
			end
			S_VEC_CS: begin
				if (acked) begin
					mem.req <= 1'b0;
					w_cs <= mem_rdata;
					state <= S_FINISH;
				end else if (!mem.req) begin
					mem <= '{req: 1'b1, we: 1'b0, addr: VEC_BASE + {10'h000, w_type, 2'b10},
						wdata: 16'h0000};
				end
			end
			S_FINISH: begin
				// a pending nmi nests on top, so its handler runs first
				if (nmi_pend) begin
					w_type <= TYPE_NMI;
					state <= S_PSH_F;
				end else begin
					state <= S_IDLE;
					busy <= 1'b0;
				end
			end
			endcase
		end
	end

	// entry result toward the core, one pulse per completed entry
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			entry_valid <= 1'b0;
			entry <= '0;
		end else begin
			entry_valid <= state == S_FINISH;
			if (state == S_FINISH) begin
				entry <= '{cs: w_cs, instruction_pointer_reg: w_ofs, flags: w_flags,
					sp: w_sp, type_num: w_type};
			end
		end
	end

	// statistics visible to software
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count <= 32'h0000_0000;
			last_type <= 8'h00;
		end else if (state == S_FINISH) begin
			count <= count + 32'h0000_0001;
			last_type <= w_type;
		end
	end

	// apb slave: answers in the first access cycle, no wait states
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= CTRL_RESET;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			if (psel && !penable) begin
				pslverr <= !(paddr == REG_CTRL || paddr == REG_STATUS || paddr == REG_COUNT);
				unique case (paddr)
				REG_CTRL: prdata <= {30'h0, ctrl};
				REG_STATUS: prdata <= {23'h0, busy, last_type};
				REG_COUNT: prdata <= count;
				default: prdata <= 32'h0000_0000;
				endcase
			end
			// write lands only at the completing edge
			if (psel && penable && pready && pwrite && paddr == REG_CTRL) begin
				ctrl <= pwdata[1:0];
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	property p_vec_range;
		(state == S_VEC_OFS || state == S_VEC_CS) && mem.req |-> mem.addr <= VEC_LAST;
	endproperty
	a_vec_range: assert property (p_vec_range) else $error("vector read outside table");
	property p_vec_addr;
		state == S_VEC_OFS && mem.req |-> mem.addr == {10'h000, w_type, 2'b00} && !mem.we;
	endproperty
	a_vec_addr: assert property (p_vec_addr) else $error("vector address not type times four");
	property p_flags_first;
		state == S_IDLE ##1 state == S_PSH_F |-> ##1 mem.req && mem.we && mem.wdata == w_flags;
	endproperty
	a_flags_first: assert property (p_flags_first) else $error("flags not pushed first");
	property p_clear_bits;
		entry_valid |-> !entry.flags[FL_INTR] && !entry.flags[FL_STEP];
	endproperty
	a_clear_bits: assert property (p_clear_bits) else $error("enable or step bit left set");
	property p_order;
		state == S_PSH_OFS && acked |=> state == S_VEC_OFS ##1 mem.req && !mem.we;
	endproperty
	a_order: assert property (p_order) else $error("vector load not after pushes");
	property p_compat_escape;
		state == S_IDLE && retire_valid && is_escape && !retire.div_error && !retire.undefined
			&& (!ctrl[CTRL_ENHANCED] || NARROW_BUS)
			|=> w_type == TYPE_ESCAPE && w_ofs == $past(retire.start_ofs);
	endproperty
	a_compat_escape: assert property (p_compat_escape) else $error("escape trap missed");
	property p_masked_escape;
		state == S_IDLE && retire_valid && is_escape && ctrl[CTRL_ENHANCED]
			&& !ctrl[CTRL_ESCAPE_EN] && !NARROW_BUS && !retire.div_error && !retire.undefined
			&& !late_hit |=> state == S_IDLE && !busy;
	endproperty
	a_masked_escape: assert property (p_masked_escape) else $error("disabled escape trapped");
	property p_breakpoint;
		state == S_IDLE && retire_valid && retire.opcode == OP_BREAK && !retire.div_error
			&& !retire.undefined |=> state == S_PSH_F && w_type == TYPE_BREAK;
	endproperty
	a_breakpoint: assert property (p_breakpoint) else $error("breakpoint not type 3");
	property p_divide;
		state == S_IDLE && retire_valid && retire.div_error |=> w_type == TYPE_DIVIDE;
	endproperty
	a_divide: assert property (p_divide) else $error("divide error not type 0");
	property p_nmi_nest;
		state == S_FINISH && nmi_pend |=> state == S_PSH_F && w_type == TYPE_NMI;
	endproperty
	a_nmi_nest: assert property (p_nmi_nest) else $error("pending nmi not nested");
	property p_no_ack_soft;
		state == S_IDLE && retire_valid && sw_hit |=> !hw_taken;
	endproperty
	a_no_ack_soft: assert property (p_no_ack_soft) else $error("software entry acknowledged");

endmodule

// ---- core/trap_pkg.sv ----
// shared constants and carrier types for the trap entry unit
package trap_pkg;
	// register offsets (byte addresses, one 32-bit word each)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_COUNT = 8'h08;
	// control fields and reset value
	localparam int CTRL_ESCAPE_EN = 0;
	localparam int CTRL_ENHANCED = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	// status fields
	localparam int STATUS_BUSY = 8;
	// vector table bounds in low memory
	localparam logic [19:0] VEC_BASE = 20'h00000;
	localparam logic [19:0] VEC_LAST = 20'h003ff;
	// predefined type numbers
	localparam logic [7:0] TYPE_DIVIDE = 8'h00;
	localparam logic [7:0] TYPE_STEP = 8'h01;
	localparam logic [7:0] TYPE_NMI = 8'h02;
	localparam logic [7:0] TYPE_BREAK = 8'h03;
	localparam logic [7:0] TYPE_OVERFLOW = 8'h04;
	localparam logic [7:0] TYPE_BOUNDS = 8'h05;
	localparam logic [7:0] TYPE_UNDEFINED = 8'h06;
	localparam logic [7:0] TYPE_ESCAPE = 8'h07;
	localparam logic [7:0] TYPE_USER_FIRST = 8'h20;
	// opcodes the unit decodes
	localparam logic [7:0] OP_BREAK = 8'hcc;
	localparam logic [7:0] OP_SOFT_TRAP = 8'hcd;
	localparam logic [7:0] OP_TRAP_OVF = 8'hce;
	localparam logic [7:0] OP_BOUNDS = 8'h62;
	localparam logic [7:0] OP_ESCAPE_BASE = 8'hd8;
	localparam logic [7:0] OP_ESCAPE_MASK = 8'hf8;
	// flag word bit positions
	localparam int FL_STEP = 8;
	localparam int FL_INTR = 9;
	localparam int FL_OVF = 11;
	// one retired instruction as seen by the trap unit
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] imm8;
		logic undefined;
		logic div_error;
		logic [15:0] flags;
		logic [15:0] cs;
		logic [15:0] ss;
		logic [15:0] sp;
		logic [15:0] start_ofs;
		logic [15:0] next_ofs;
		logic [15:0] index;
		logic [15:0] bound_seg;
		logic [15:0] bound_ofs;
	} retire_s;
	// new processor state after an entry
	typedef struct packed {
		logic [15:0] cs;
		logic [15:0] instruction_pointer_reg;
		logic [15:0] flags;
		logic [15:0] sp;
		logic [7:0] type_num;
	} entry_s;
	// word request toward system memory
	typedef struct packed {
		logic req;
		logic we;
		logic [19:0] addr;
		logic [15:0] wdata;
	} mem_req_s;
endpackage

// ---- verif/testbench.sv ----
// self-checking bench for the trap entry unit
`timescale 1ns/10ps
module testbench;
	import trap_pkg::*;
	logic clock, arst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic retire_valid, busy, entry_valid, nmi_pin, intr_req, hw_taken, mem_ack, er;
	logic [7:0] intr_type;
	logic [15:0] mem_rdata;
	logic [3:0] delay;
	retire_s retire;
	entry_s entry;
	mem_req_s mem;
	int errors, num_checks, ev_cnt, hw_cnt;
	localparam logic [15:0] IFB = 16'h0200;
	localparam logic [15:0] TFB = 16'h0100;
	localparam logic [15:0] OFB = 16'h0800;
	cpu_trap_exception_entry dut (.clock(clock), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.retire_valid(retire_valid), .retire(retire), .busy(busy),
		.entry_valid(entry_valid), .entry(entry), .nmi_pin(nmi_pin),
		.intr_req(intr_req), .intr_type(intr_type), .hw_taken(hw_taken),
		.mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	trap_mem_model mem_model (.clock(clock), .arst_n(arst_n), .mem(mem),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .delay(delay));
	// clock at 25 mhz
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// count entries and hardware acceptances as they happen
	always @(posedge clock) begin
		if (entry_valid === 1'b1) ev_cnt++;
		if (hw_taken === 1'b1) hw_cnt++;
	end
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer; holds the request until pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			errors++;
			print_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge so the next call never drives psel twice at once
		@(posedge clock);
	endtask
	// retire one instruction and compare the entry it causes, if any
	task automatic run(input logic [7:0] op, input logic [7:0] imm, input logic und,
		input logic dv, input logic [15:0] fl, input logic [15:0] idx, input logic ev,
		input logic [7:0] ty, input logic [15:0] ret);
		int i, w0, e0;
		w0 = mem_model.wn;
		e0 = ev_cnt;
		retire <= '{opcode: op, imm8: imm, undefined: und, div_error: dv, flags: fl,
			cs: 16'h1234, ss: 16'h0200, sp: 16'h0100, start_ofs: 16'h0050,
			next_ofs: 16'h0052, index: idx, bound_seg: 16'h0100, bound_ofs: 16'h0010};
		retire_valid <= 1'b1;
		@(posedge clock);
		retire_valid <= 1'b0;
		@(posedge clock);
		chk(32'(busy), 32'(ev | (op == OP_BOUNDS)));
		for (i = 0; i < 300 && ev_cnt == e0; i++) @(posedge clock);
		if (!ev) begin
			chk(32'(ev_cnt - e0), 32'h0);
			return;
		end
		if (i == 300) begin
			errors++;
			print_verdict();
		end
		chk(32'(entry.type_num), 32'(ty));
		chk(32'(entry.instruction_pointer_reg), 32'({8'h5a, ty}));
		chk(32'(entry.cs), 32'({8'h3c, ty}));
		chk(32'(entry.flags), 32'(fl & ~(IFB | TFB)));
		chk(32'(entry.sp), 32'h00fa);
		chk(32'(mem_model.wn - w0), 32'h3);
		chk(32'(mem_model.wlog_addr[w0]), 32'h020fe);
		chk(32'(mem_model.wlog_data[w0]), 32'(fl));
		chk(32'(mem_model.wlog_data[w0 + 1]), 32'h1234);
		chk(32'(mem_model.wlog_addr[w0 + 2]), 32'h020fa);
		chk(32'(mem_model.wlog_data[w0 + 2]), 32'(ret));
	endtask
	// wait, bounded, for one more entry pulse
	task automatic wait_entry();
		int i, e0;
		e0 = ev_cnt;
		for (i = 0; i < 300 && ev_cnt == e0; i++) @(posedge clock);
		if (i == 300) begin
			errors++;
			print_verdict();
		end
	endtask
	initial begin
		int h0;
		{psel, penable, pwrite, paddr, pwdata, retire_valid, nmi_pin, intr_req} = '0;
		retire = '0;
		intr_type = 8'h48;
		delay = 4'h0;
		arst_n = 1'b0;
		repeat (4) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd, 32'(CTRL_RESET));
		apb(1'b0, 8'h40, 32'h0);
		chk(32'(er), 32'h1);
		// software traps ignore the enable flag and never count as hardware
		intr_req <= 1'b1;
		h0 = hw_cnt;
		run(OP_BREAK, 8'h00, 0, 0, IFB | TFB, 0, 1, TYPE_BREAK, 16'h0052);
		run(OP_SOFT_TRAP, 8'hfe, 0, 0, IFB, 0, 1, 8'hfe, 16'h0052);
		chk(32'(hw_cnt - h0), 32'h0);
		run(8'h90, 8'h00, 0, 0, IFB, 0, 1, 8'h48, 16'h0052);
		chk(32'(hw_cnt - h0), 32'h1);
		intr_req <= 1'b0;
		delay <= 4'h3;
		run(8'hf6, 8'h00, 0, 1, 16'h0000, 0, 1, TYPE_DIVIDE, 16'h0052);
		delay <= 4'h0;
		run(OP_TRAP_OVF, 8'h00, 0, 0, OFB, 0, 1, TYPE_OVERFLOW, 16'h0052);
		run(OP_TRAP_OVF, 8'h00, 0, 0, 16'h0000, 0, 0, 0, 0);
		run(8'h0f, 8'h00, 1, 0, 16'h0000, 0, 1, TYPE_UNDEFINED, 16'h0050);
		run(OP_BOUNDS, 8'h00, 0, 0, 16'h0000, 16'h1011, 0, 0, 0);
		run(OP_BOUNDS, 8'h00, 0, 0, 16'h0000, 16'h2000, 1, TYPE_BOUNDS, 16'h0050);
		run(8'h90, 8'h00, 0, 0, TFB, 0, 1, TYPE_STEP, 16'h0052);
		run(8'h90, 8'h00, 0, 0, TFB | IFB, 0, 1, TYPE_STEP, 16'h0052);
		// escape: compatible always traps, enhanced follows the enable bit
		run(8'hdf, 8'h00, 0, 0, 16'h0000, 0, 1, TYPE_ESCAPE, 16'h0050);
		apb(1'b1, REG_CTRL, 32'h2);
		run(8'hd8, 8'h00, 0, 0, 16'h0000, 0, 0, 0, 0);
		apb(1'b1, REG_CTRL, 32'h3);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd, 32'h3);
		run(8'hd9, 8'h00, 0, 0, 16'h0000, 0, 1, TYPE_ESCAPE, 16'h0050);
		// an nmi latched before a software trap is entered on top of it
		nmi_pin <= 1'b1;
		repeat (3) @(posedge clock);
		nmi_pin <= 1'b0;
		repeat (3) @(posedge clock);
		run(OP_BREAK, 8'h00, 0, 0, IFB, 0, 1, TYPE_BREAK, 16'h0052);
		wait_entry();
		chk(32'(entry.type_num), 32'(TYPE_NMI));
		chk(32'(entry.instruction_pointer_reg), 32'({8'h5a, TYPE_NMI}));
		chk(32'(entry.flags), 32'h0);
		// latched nmi outranks a pending maskable request
		intr_req <= 1'b1;
		nmi_pin <= 1'b1;
		repeat (3) @(posedge clock);
		nmi_pin <= 1'b0;
		repeat (3) @(posedge clock);
		run(8'h90, 8'h00, 0, 0, IFB, 0, 1, TYPE_NMI, 16'h0052);
		intr_req <= 1'b0;
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd, 32'(TYPE_NMI));
		apb(1'b0, REG_COUNT, 32'h0);
		chk(rd, 32'h0000_000e);
		print_verdict();
	end
endmodule

// ---- verif/trap_mem_model.sv ----
// behavioural system memory giving a patterned vector table and logging the stack writes
`timescale 1ns/10ps
module trap_mem_model (
	// clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// word requests from the trap unit
	input wire trap_pkg::mem_req_s mem,
	output logic mem_ack,
	output logic [15:0] mem_rdata,
	// wait cycles before each answer
	input wire logic [3:0] delay
);
	import trap_pkg::*;
	logic [3:0] cnt;
	logic [19:0] wlog_addr [0:63];
	logic [15:0] wlog_data [0:63];
	int wn;
	// vector entries hold a pattern tied to the type; other reads return the address
	function automatic logic [15:0] rd_word(input logic [19:0] a);
		if (a <= VEC_LAST)
			return a[1] ? {8'h3c, a[9:2]} : {8'h5a, a[9:2]};
		return a[15:0];
	endfunction
	// answer after delay cycles; between answers the data lines toggle so stale data is not read
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			mem_ack <= 1'b0;
			cnt <= 4'h0;
			mem_rdata <= 16'h0000;
			wn <= 0;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem.req && !mem_ack) begin
				if (cnt == delay) begin
					mem_ack <= 1'b1;
					cnt <= 4'h0;
					if (mem.we) begin
						wlog_addr[wn[5:0]] <= mem.addr;
						wlog_data[wn[5:0]] <= mem.wdata;
						wn <= wn + 1;
					end else begin
						mem_rdata <= rd_word(mem.addr);
					end
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	end
endmodule
